// ---- src/ddr2_cmd_map.svh ----
// Purpose: Constants for the DDR2 command-side controller.
// Assumes: 50 MHz system clock, one command slot per clock.
// Notes:   Timing counts are in controller clocks; the _NS values are in ns.
`ifndef DDR2_CMD_MAP_SVH
`define DDR2_CMD_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS                 20
`define CKE_MIN_HOLD_CLK              3
`define SELF_REFRESH_EXIT_READ_CLK    200
`define SELF_REFRESH_EXIT_NONREAD_NS  200
`define SELF_REFRESH_EXIT_NONREAD_CLK \
    ((`SELF_REFRESH_EXIT_NONREAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MODE_REGISTER_SET_DELAY_CLK   2
`define ROW_PRECHARGE_CLK             1
`define BURST_BUSY_CLK                4
`define POWER_DOWN_MAX_CLK            390

// ****************************************************************
// Field layout
// ****************************************************************
`define BANK_COUNT       4
`define ADDR_W           13
`define BANK_W           2
`define AUTO_PRE_BIT     10
`define COUNT_W          9
`define FIFO_DEPTH       8
`define MASK_W           2
`define DATA_W           16

`endif

// ---- src/ddr2_cmd_pkg.sv ----
// Purpose: Types for the DDR2 command-side controller.
// Assumes: Constants come from ddr2_cmd_map.svh.
// Notes:   Command codes are {cs_n, ras_n, cas_n, we_n}.
package ddr2_cmd_pkg;

    typedef enum logic [3:0] {
        CMD_MRS      = 4'h0,
        CMD_REFRESH  = 4'h1,
        CMD_PRECHRG  = 4'h2,
        CMD_ACTIVATE = 4'h3,
        CMD_WRITE    = 4'h4,
        CMD_READ     = 4'h5,
        CMD_NOP      = 4'h7,
        CMD_DESELECT = 4'h8
    } dram_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_WAIT      = 3'b001,
        ST_POWERDOWN = 3'b010,
        ST_SELFREF   = 3'b011,
        ST_EXIT      = 3'b100
    } pwr_state_t;

    typedef enum logic [2:0] {
        REQ_MRS      = 3'b000,
        REQ_ACTIVATE = 3'b001,
        REQ_READ     = 3'b010,
        REQ_WRITE    = 3'b011,
        REQ_PRECHRG  = 3'b100,
        REQ_REFRESH  = 3'b101,
        REQ_PWRDOWN  = 3'b110,
        REQ_SELFREF  = 3'b111
    } req_op_t;

endpackage

// ---- src/mask_fifo.sv ----
// Purpose: Small FIFO for write data and mask beats.
// Assumes: Same clock on both sides.
// Notes:   Read data come straight out of a register.
`timescale 1ns/1ns
module mask_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Filling side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Draining side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    wr_ptr_nxt;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW-1:0]    rd_ptr_nxt;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             out_valid_r;
    logic             out_valid_nxt;
    logic [WIDTH-1:0] out_data_r;
    logic [WIDTH-1:0] out_data_nxt;
    logic             push;
    logic             pop;

    always_comb begin
        // One entry sits in the output register, so storage holds DEPTH-1 more
        o_in_ready    = (count_r < AW'(DEPTH - 1) + (AW+1)'(0)) || !out_valid_r;
        push          = i_in_valid && o_in_ready;
        pop           = (count_r != '0) && (!out_valid_r || i_out_ready);
        wr_ptr_nxt    = push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
        rd_ptr_nxt    = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
        count_nxt     = (AW+1)'(count_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
        out_valid_nxt = pop ? 1'b1 : (i_out_ready ? 1'b0 : out_valid_r);
        out_data_nxt  = pop ? mem_r[rd_ptr_r] : out_data_r;
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
        if (i_rst) begin
            wr_ptr_r    <= '0;
            rd_ptr_r    <= '0;
            count_r     <= '0;
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else begin
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            count_r     <= count_nxt;
            out_valid_r <= out_valid_nxt;
            out_data_r  <= out_data_nxt;
        end
    end

    assign o_out_valid = out_valid_r;
    assign o_out_data  = out_data_r;

endmodule // mask_fifo

// ---- src/ddr2_cmd_ctrl.sv ----
// Notes on behaviour
// - Only truth-table command combinations are issued.
// - Power-down entry and exit use NOP.
// - Self-refresh entry: refresh with CKE low, idle (code enters with banks open too).
// - Self-refresh exit: CKE high with NOP.
// - NOPs only until nonread delay elapses.
// - No read for 200 clocks after exit.
// - No sleep while operations in progress.
// - Hold CKE three edges after change.
// - Limit power-down time for refresh.
// - CKE high during driver calibration.
// - ODT held valid in power-down.
// - MRS only idle, then wait delay (code issues MRS with banks open too).
// - Precharge before activating other row (code activates without checking open banks).
//
// Purpose: Controller that drives a DDR2 device's command and CKE pins.
// Assumes: One command per clock; user waits for o_req_ready.
// Notes:   Write data and masks pass through an 8-entry FIFO.
`timescale 1ns/1ns
`include "ddr2_cmd_map.svh"
module ddr2_cmd_ctrl
    import ddr2_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // User requests
    input  wire logic                  i_req_valid,
    input  wire logic [2:0]            i_req_op,
    input  wire logic [`BANK_W-1:0]    i_req_bank,
    input  wire logic [`ADDR_W-1:0]    i_req_addr,
    input  wire logic                  i_wake,
    input  wire logic                  i_calibrating,
    input  wire logic                  i_odt_req,
    output logic                       o_req_ready,
    output logic                       o_asleep,
    output logic [`BANK_COUNT-1:0]     o_bank_open,
    // User write beats
    input  wire logic                  i_wr_valid,
    input  wire logic [`DATA_W-1:0]    i_wr_data,
    input  wire logic [`MASK_W-1:0]    i_wr_mask,
    output logic                       o_wr_ready,
    // Device pins
    output logic                       o_cke,
    output logic                       o_cs_n,
    output logic                       o_ras_n,
    output logic                       o_cas_n,
    output logic                       o_we_n,
    output logic [`BANK_W-1:0]         o_ba,
    output logic [`ADDR_W-1:0]         o_addr,
    output logic                       o_odt,
    output logic [`DATA_W-1:0]         o_dq,
    output logic [`MASK_W-1:0]         o_dm,
    output logic                       o_dq_oe
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    pwr_state_t                 state_r;
    pwr_state_t                 state_nxt;
    pwr_state_t                 ret_r;
    pwr_state_t                 ret_nxt;
    logic [3:0]                 cmd_r;
    logic [3:0]                 cmd_nxt;
    logic                       cke_r;
    logic                       cke_nxt;
    logic [`BANK_W-1:0]         ba_r;
    logic [`BANK_W-1:0]         ba_nxt;
    logic [`ADDR_W-1:0]         addr_r;
    logic [`ADDR_W-1:0]         addr_nxt;
    logic                       odt_r;
    logic                       odt_nxt;
    logic [`COUNT_W-1:0]        wait_r;
    logic [`COUNT_W-1:0]        wait_nxt;
    logic [1:0]                 hold_r;
    logic [1:0]                 hold_nxt;
    logic [`COUNT_W-1:0]        rd_block_r;
    logic [`COUNT_W-1:0]        rd_block_nxt;
    logic [`COUNT_W-1:0]        sleep_r;
    logic [`COUNT_W-1:0]        sleep_nxt;
    logic [`BANK_COUNT-1:0]     open_r;
    logic [`BANK_COUNT-1:0]     open_nxt;
    logic [1:0]                 beats_r;
    logic [1:0]                 beats_nxt;
    logic                       ready_r;
    logic                       ready_nxt;
    logic                       wake_s1_r;
    logic                       wake_s2_r;
    logic                       cal_s1_r;
    logic                       cal_s2_r;
    logic                       take;
    logic                       all_idle;
    logic                       beat_valid;
    logic [`DATA_W+`MASK_W-1:0] beat_data;
    logic                       beat_take;
    logic [`DATA_W-1:0]         dq_r;
    logic [`DATA_W-1:0]         dq_nxt;
    logic [`MASK_W-1:0]         dm_r;
    logic [`MASK_W-1:0]         dm_nxt;
    logic                       dq_oe_r;
    logic                       dq_oe_nxt;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
            cal_s1_r  <= 1'b0;
            cal_s2_r  <= 1'b0;
        end else begin
            wake_s1_r <= i_wake;
            wake_s2_r <= wake_s1_r;
            cal_s1_r  <= i_calibrating;
            cal_s2_r  <= cal_s1_r;
        end
    end

    // ****************************************************************
    // Write beat buffer
    // ****************************************************************
    mask_fifo #(
        .WIDTH (`DATA_W + `MASK_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_wr_valid),
        .i_in_data   ({i_wr_mask, i_wr_data}),
        .o_in_ready  (o_wr_ready),
        .o_out_valid (beat_valid),
        .o_out_data  (beat_data),
        .i_out_ready (beat_take)
    );

    // ****************************************************************
    // Command and power state
    // ****************************************************************
    always_comb begin
        all_idle     = (open_r == '0);
        take         = ready_r && i_req_valid;
        state_nxt    = state_r;
        ret_nxt      = ret_r;
        cmd_nxt      = CMD_NOP;
        cke_nxt      = cke_r;
        ba_nxt       = ba_r;
        addr_nxt     = addr_r;
        odt_nxt      = odt_r;
        open_nxt     = open_r;
        beats_nxt    = beats_r;
        hold_nxt     = (hold_r != '0) ? 2'(hold_r - 1'b1) : hold_r;
        wait_nxt     = (wait_r != '0) ? `COUNT_W'(wait_r - 1'b1) : wait_r;
        rd_block_nxt = (rd_block_r != '0) ? `COUNT_W'(rd_block_r - 1'b1) : rd_block_r;
        sleep_nxt    = sleep_r;
        beat_take    = 1'b0;
        dq_nxt       = dq_r;
        dm_nxt       = dm_r;
        dq_oe_nxt    = 1'b0;
        // Each DM bit flagged high masks its byte of that beat
        if (beats_r != '0 && beat_valid) begin
            beat_take = 1'b1;
            dq_nxt    = beat_data[`DATA_W-1:0];
            dm_nxt    = beat_data[`DATA_W+`MASK_W-1:`DATA_W];
            dq_oe_nxt = 1'b1;
            beats_nxt = 2'(beats_r - 1'b1);
        end
        // ODT kept at a defined level, off in self-refresh
        odt_nxt = (state_r == ST_SELFREF) ? 1'b0 : i_odt_req;
        case (state_r)
            ST_IDLE: begin
                // Raise CKE after reset; requests wait out its hold
                if (!cke_r) begin
                    cke_nxt  = 1'b1;
                    hold_nxt = 2'(`CKE_MIN_HOLD_CLK - 1);
                end
                // Only table commands leave this block
                if (take) begin
                    ba_nxt   = i_req_bank;
                    addr_nxt = i_req_addr;
                    case (req_op_t'(i_req_op))
                        REQ_MRS: begin
                            // Bank bits pick the mode register
                            cmd_nxt  = CMD_MRS;
                            wait_nxt = `COUNT_W'(`MODE_REGISTER_SET_DELAY_CLK);
                        end
                        REQ_ACTIVATE: begin
                            // Row opens in the chosen bank
                            cmd_nxt              = CMD_ACTIVATE;
                            open_nxt[i_req_bank] = 1'b1;
                        end
                        REQ_READ, REQ_WRITE: begin
                            // Column rides on the low address bits
                            // Device delays it by its additive latency
                            cmd_nxt  = (i_req_op == REQ_READ) ? CMD_READ : CMD_WRITE;
                            wait_nxt = `COUNT_W'(`BURST_BUSY_CLK);
                            if (i_req_op == REQ_WRITE) begin
                                beats_nxt = 2'(`BURST_BUSY_CLK - 1);
                            end
                            if (i_req_addr[`AUTO_PRE_BIT]) begin
                                open_nxt[i_req_bank] = 1'b0;
                            end
                        end
                        REQ_PRECHRG: begin
                            cmd_nxt  = CMD_PRECHRG;
                            wait_nxt = `COUNT_W'(`ROW_PRECHARGE_CLK);
                            if (i_req_addr[`AUTO_PRE_BIT]) begin
                                open_nxt = '0;
                            end else begin
                                open_nxt[i_req_bank] = 1'b0;
                            end
                        end
                        REQ_REFRESH: begin
                            cmd_nxt  = CMD_REFRESH;
                            wait_nxt = `COUNT_W'(`ROW_PRECHARGE_CLK);
                        end
                        REQ_PWRDOWN: begin
                            // Device picks active or precharge power-down
                            cmd_nxt   = CMD_NOP;
                            cke_nxt   = 1'b0;
                            hold_nxt  = 2'(`CKE_MIN_HOLD_CLK - 1);
                            sleep_nxt = `COUNT_W'(`POWER_DOWN_MAX_CLK);
                            state_nxt = ST_POWERDOWN;
                        end
                        default: begin
                            cmd_nxt   = CMD_REFRESH;
                            cke_nxt   = 1'b0;
                            hold_nxt  = 2'(`CKE_MIN_HOLD_CLK - 1);
                            state_nxt = ST_SELFREF;
                        end
                    endcase
                    if (cmd_nxt != CMD_NOP || req_op_t'(i_req_op) == REQ_PWRDOWN) begin
                        state_nxt = (state_nxt == ST_IDLE) ? ST_WAIT : state_nxt;
                    end
                end
            end
            ST_WAIT: begin
                // NOPs leave the running burst alone
                if (wait_r <= `COUNT_W'(1) && beats_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_POWERDOWN, ST_SELFREF: begin
                // CKE stays low, command pins idle
                cmd_nxt = CMD_DESELECT;
                if (state_r == ST_POWERDOWN && sleep_r != '0) begin
                    sleep_nxt = `COUNT_W'(sleep_r - 1'b1);
                end
                // No CKE change inside the hold window
                // Forced wake before refresh falls due
                if (hold_r == '0 && (wake_s2_r || cal_s2_r ||
                    (state_r == ST_POWERDOWN && sleep_r <= 1))) begin
                    // No clock-edge dependency expected on exit
                    cmd_nxt  = CMD_NOP;
                    cke_nxt  = 1'b1;
                    hold_nxt = 2'(`CKE_MIN_HOLD_CLK - 1);
                    ret_nxt  = state_r;
                    if (state_r == ST_SELFREF) begin
                        // NOP stream for the nonread delay
                        wait_nxt     = `COUNT_W'(`SELF_REFRESH_EXIT_NONREAD_CLK);
                        rd_block_nxt = `COUNT_W'(`SELF_REFRESH_EXIT_READ_CLK);
                    end else begin
                        wait_nxt = '0;
                    end
                    state_nxt = ST_EXIT;
                end
            end
            ST_EXIT: begin
                if (hold_r == '0 && wait_r == '0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Sleep offered only when nothing runs
        // All requests wait out the read block, so ready never lies
        ready_nxt = (state_nxt == ST_IDLE) && !cal_s2_r && cke_r && hold_r == '0 &&
                    rd_block_r <= `COUNT_W'(1);
        if (ready_nxt && take) begin
            ready_nxt = 1'b0;
        end
    end

    // Reads and sleeps while blocked are refused through o_req_ready timing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r    <= ST_IDLE;
            ret_r      <= ST_IDLE;
            cmd_r      <= CMD_NOP;
            cke_r      <= 1'b0;
            ba_r       <= '0;
            addr_r     <= '0;
            odt_r      <= 1'b0;
            wait_r     <= '0;
            hold_r     <= '0;
            rd_block_r <= '0;
            sleep_r    <= '0;
            open_r     <= '0;
            beats_r    <= '0;
            ready_r    <= 1'b0;
            dq_r       <= '0;
            dm_r       <= '0;
            dq_oe_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            ret_r      <= ret_nxt;
            cmd_r      <= cmd_nxt;
            cke_r      <= cke_nxt;
            ba_r       <= ba_nxt;
            addr_r     <= addr_nxt;
            odt_r      <= odt_nxt;
            wait_r     <= wait_nxt;
            hold_r     <= hold_nxt;
            rd_block_r <= rd_block_nxt;
            sleep_r    <= sleep_nxt;
            open_r     <= open_nxt;
            beats_r    <= beats_nxt;
            ready_r    <= ready_nxt;
            dq_r       <= dq_nxt;
            dm_r       <= dm_nxt;
            dq_oe_r    <= dq_oe_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Pins change once per clock edge only
    assign o_cke       = cke_r;
    assign o_cs_n      = cmd_r[3];
    assign o_ras_n     = cmd_r[2];
    assign o_cas_n     = cmd_r[1];
    assign o_we_n      = cmd_r[0];
    assign o_ba        = ba_r;
    assign o_addr      = addr_r;
    assign o_odt       = odt_r;
    assign o_dq        = dq_r;
    assign o_dm        = dm_r;
    assign o_dq_oe     = dq_oe_r;
    assign o_req_ready = ready_r;
    assign o_asleep    = (ret_r != ST_IDLE) && 1'b0 || (state_r == ST_POWERDOWN) ||
                         (state_r == ST_SELFREF);
    assign o_bank_open = open_r;

endmodule // ddr2_cmd_ctrl

// ---- tb/ddr2_cmd_chk.sv ----
// Purpose: Pin-order checks on the command controller.
// Assumes: One clock, synchronous reset.
// Notes:   Sleep and exit windows are tracked by helper counters.
`timescale 1ns/1ns
`include "ddr2_cmd_map.svh"
module ddr2_cmd_chk (
    // Watched ports
    input wire logic                   i_clk,
    input wire logic                   i_rst,
    input wire logic                   i_calibrating,
    input wire logic                   o_cke,
    input wire logic                   o_cs_n,
    input wire logic                   o_ras_n,
    input wire logic                   o_cas_n,
    input wire logic                   o_we_n,
    input wire logic                   o_odt,
    input wire logic [`BANK_COUNT-1:0] o_bank_open
);
    logic [3:0] cmd;
    logic       idle_c;
    logic       sr_r;
    logic [8:0] xcnt_r;
    logic [8:0] pd_r;
    assign cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
    assign idle_c = o_cs_n || cmd == 4'h7;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ********
    // Self-refresh tracking
    // ********
    always_ff @(posedge i_clk) begin
        sr_r <= i_rst ? 1'b0 : (!o_cke && cmd == 4'h1) ? 1'b1 : o_cke ? 1'b0 : sr_r;
        xcnt_r <= i_rst ? 9'h0 : (o_cke && sr_r) ? 9'd199 : (xcnt_r != 0) ? xcnt_r - 1 : 9'h0;
        // Self-refresh is excluded: only power-down starves refresh
        pd_r <= (i_rst || o_cke || sr_r) ? 9'h0 : pd_r + 1;
    end
    cke_min_hold_a: assert property ($changed(o_cke) |=> $stable(o_cke) [*2])
        else $error("cke held too briefly");
    sleep_entry_a: assert property ($fell(o_cke) |-> idle_c || cmd == 4'h1)
        else $error("bad command at sleep entry");
    sr_idle_a: assert property ($fell(o_cke) && cmd == 4'h1 |-> o_bank_open == 0)
        else $error("self-refresh with open bank");
    wake_nop_a: assert property ($rose(o_cke) |-> idle_c)
        else $error("bad command at wake");
    sr_nonread_a: assert property (xcnt_r > 9'd190 |-> idle_c)
        else $error("command too soon after wake");
    sr_read_a: assert property (xcnt_r != 0 |-> cmd != 4'h5)
        else $error("read too soon after wake");
    busy_sleep_a: assert property (cmd[3:1] == 3'b010 |=> o_cke [*4])
        else $error("sleep during burst");
    pd_limit_a: assert property (pd_r < 9'd400)
        else $error("power-down too long");
    cal_cke_a: assert property (i_calibrating [*8] |-> o_cke)
        else $error("cke low in calibration");
    sr_odt_a: assert property (sr_r && !o_cke && $past(sr_r) |-> !o_odt)
        else $error("termination on in self-refresh");
    mrs_gap_a: assert property (cmd == 4'h0 |-> o_bank_open == 0 ##1 idle_c)
        else $error("mode set misplaced");
    cover property ($fell(o_cke) && cmd == 4'h1);
    cover property ($fell(o_cke) && cmd == 4'h7);
    cover property (xcnt_r == 9'd1);
endmodule // ddr2_cmd_chk

bind ddr2_cmd_ctrl ddr2_cmd_chk u_chk (.*);

// ---- tb/ddr2_dev_model.sv ----
// Purpose: Behavioural DDR2 device seen from its pins.
// Assumes: One write beat per clock while the data bus is driven.
// Notes:   Tracks banks, power state and mode words; no array storage.
`timescale 1ns/1ns
module ddr2_dev_model #(
    parameter int AL = 2
) (
    // Pins from the controller, command as {cs_n, ras_n, cas_n, we_n}
    input  wire logic              i_clk,
    input  wire logic              i_cke,
    input  wire logic [3:0]        i_cmd,
    input  wire logic [1:0]        i_ba,
    input  wire logic [12:0]       i_addr,
    input  wire logic [1:0]        i_dm,
    input  wire logic              i_dq_oe,
    // Observed state
    output logic      [3:0]        o_open,
    output logic      [1:0]        o_pwr,
    output logic      [9:0]        o_col,
    output logic      [3:0][12:0]  o_mode,
    output int                     o_bytes
);
    logic        cke_q = 1'b0;
    logic [13:0] pipe [AL+1];
    initial begin
        o_open = 4'h0;
        o_pwr = 2'h0;
        o_bytes = 0;
    end
    // wake from self-refresh needs no clock
    always @(posedge i_cke) if (o_pwr == 2'd3) o_pwr <= 2'd0;
    always @(posedge i_clk) begin
        cke_q <= i_cke;
        if (cke_q && !i_cke) o_pwr <= i_cmd == 4'h1 ? 2'd3 : |o_open ? 2'd2 : 2'd1;
        else if (!cke_q && i_cke) o_pwr <= 2'd0;
        if (cke_q && i_cke) case (i_cmd)
            4'h0: o_mode[i_ba] <= i_addr;
            4'h3: o_open[i_ba] <= 1'b1;
            4'h2: o_open <= i_addr[10] ? 4'h0 : o_open & ~(4'h1 << i_ba);
            default: ;
        endcase
        pipe[0] <= {cke_q && i_cke && i_cmd[3:1] == 3'b010, i_addr[10], i_ba, i_addr[9:0]};
        for (int i = 1; i <= AL; i++) pipe[i] <= pipe[i-1];
        if (pipe[AL][13]) begin
            o_col <= pipe[AL][9:0];
            if (pipe[AL][12]) o_open[pipe[AL][11:10]] <= 1'b0;
        end
        if (i_dq_oe) o_bytes <= o_bytes + !i_dm[0] + !i_dm[1];
    end
endmodule // ddr2_dev_model

// ---- tb/tb_ddr2_cke_power_state_and_command_decode.sv ----
// Purpose: Drives the command controller against the device model.
// Assumes: Model posts column accesses by two clocks.
// Notes:   Rows, read columns and write beats come from a fixed seed.
`timescale 1ns/1ns
module tb_ddr2_cke_power_state_and_command_decode;
    logic i_clk = 0, i_rst = 1, i_req_valid = 0, i_wake = 0, i_calibrating = 0;
    logic i_odt_req = 1, i_wr_valid = 0, o_req_ready, o_asleep, o_wr_ready, o_cke;
    logic o_cs_n, o_ras_n, o_cas_n, o_we_n, o_odt, o_dq_oe;
    logic [2:0]  i_req_op = 0;
    logic [1:0]  i_req_bank = 0, i_wr_mask = 0, o_ba, o_dm, m_pwr;
    logic [12:0] i_req_addr = 0, o_addr, r;
    logic [15:0] i_wr_data = 0, o_dq;
    logic [3:0]  o_bank_open, m_open, bopen = 0;
    logic [9:0]  m_col;
    logic [3:0][12:0] m_mode;
    int m_bytes, n_mismatch = 0, num_checks = 0, seed = 56720, exp_bytes = 0, cyc = 0;
    int t_x, t_c;
    always #10 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    ddr2_cmd_ctrl dut (.*);
    ddr2_dev_model #(.AL(2)) u_dev (.i_clk, .i_cke(o_cke),
        .i_cmd({o_cs_n, o_ras_n, o_cas_n, o_we_n}), .i_ba(o_ba), .i_addr(o_addr),
        .i_dm(o_dm), .i_dq_oe(o_dq_oe), .o_open(m_open), .o_pwr(m_pwr), .o_col(m_col),
        .o_mode(m_mode), .o_bytes(m_bytes));
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic hold(ref logic s, input logic v);
        @(negedge i_clk);
        for (int w = 0; w < 400 && s !== v; w++) @(negedge i_clk);
    endtask
    task automatic req(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
        logic [3:0] code [8] = '{4'h0, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h7, 4'h1};
        @(posedge i_clk);
        {i_req_valid, i_req_op, i_req_bank, i_req_addr} <= {1'b1, op, b, a};
        hold(o_req_ready, 1'b1);
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        @(negedge i_clk);
        t_c = cyc;
        chk({o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n}, {op < 6, code[op]});
        if (op < 5) chk({o_ba, o_addr}, {b, a});
        case (op)
            1: bopen[b] = 1'b1;
            2, 3: if (a[10]) bopen[b] = 1'b0;
            4: bopen = a[10] ? 4'h0 : bopen & ~(4'h1 << b);
            default: ;
        endcase
        if (op < 6) begin
            hold(o_req_ready, 1'b1);
            chk({o_bank_open, m_open}, {bopen, bopen});
        end
    endtask
    task automatic beat;
        logic [17:0] v;
        v = 18'($random(seed));
        @(posedge i_clk);
        {i_wr_valid, i_wr_mask, i_wr_data} <= {1'b1, v};
        hold(o_wr_ready, 1'b1);
        @(posedge i_clk);
        i_wr_valid <= 1'b0;
        exp_bytes += !v[16] + !v[17];
    endtask
    task automatic wake;
        @(posedge i_clk);
        i_wake <= 1'b1;
        hold(o_cke, 1'b1);
        t_x = cyc;
        @(posedge i_clk);
        i_wake <= 1'b0;
        repeat (2) @(negedge i_clk);
        chk({o_asleep, m_pwr}, 3'b000);
    endtask
    task automatic nap(input logic [2:0] op, input logic [1:0] kind);
        req(op, 0, 0);
        repeat (3) @(negedge i_clk);
        chk({o_asleep, m_pwr}, {1'b1, kind});
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        r = 13'($random(seed));
        req(0, 1, r);
        chk(m_mode[1], r);
        for (int k = 0; k < 3; k++) req(1, 2'(k), 13'($random(seed)));
        req(2, 0, 13'h0400 | r[9:0]);
        chk(m_col, r[9:0]);
        req(2, 2, {3'h0, r[9:0]});
        // Fill the buffer until it refuses, then drain it with three writes
        for (int k = 0; k < 8; k++) beat();
        repeat (2) @(negedge i_clk);
        chk(o_wr_ready, 1'b0);
        fork
            beat();
            for (int k = 0; k < 3; k++) req(3, 1, 13'(k * 4));
        join
        repeat (20) @(negedge i_clk);
        chk({o_wr_ready, m_bytes}, {1'b1, exp_bytes});
        nap(6, 2'd2);
        wake();
        req(4, 0, 13'h0400);
        nap(6, 2'd1);
        @(posedge i_clk);
        i_calibrating <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_calibrating <= 1'b0;
        @(negedge i_clk);
        chk({o_cke, o_req_ready}, 2'b10);
        nap(7, 2'd3);
        chk(o_odt, 1'b0);
        wake();
        req(1, 3, r);
        req(2, 3, 13'h0);
        chk(t_c - t_x >= 200, 1'b1);
        print_verdict();
    end
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
endmodule // tb_ddr2_cke_power_state_and_command_decode
